// >>> pulse_channel.sv
`timescale 1ns/1ns
// one counting channel: synchronised rising-edge counter with clear
module pulse_channel
    import pulse_counter_pkg::*;
#(
    parameter int unsigned WIDTH = COUNT_WIDTH
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             pulse_pin,
    input  wire logic             enable,
    input  wire logic             clear,
    output logic [WIDTH-1:0]      count,
    output logic                  pulse_seen,
    output logic                  wrap
);
    logic             pin_sync;
    logic             prev_reg;
    logic [WIDTH-1:0] count_next;

    sync_two_stage u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pulse_pin),
        .sync_out (pin_sync)
    );

    // edge found on synchronised level; a 2 MHz source leaves 50 cycles per period
    assign pulse_seen = pin_sync & ~prev_reg & enable;
    assign wrap       = pulse_seen & ~clear & (&count);
    // clear wins over a pulse in the same cycle
    assign count_next = clear ? '0 : (pulse_seen ? count + 1'b1 : count);

    // counting runs with no software involvement
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 1'b0;
            count    <= '0;
        end else begin
            prev_reg <= pin_sync;
            count    <= count_next;
        end
    end

    chk_count_step: assert property (@(posedge pclk) disable iff (!presetn)
        pulse_seen && !clear |=> count == $past(count) + 1'b1)
        else $error("count did not advance on a pulse");
    chk_wrap_zero: assert property (@(posedge pclk) disable iff (!presetn)
        wrap |=> count == '0 ##1 1'b1)
        else $error("count did not wrap to zero");
    chk_read_stable: assert property (@(posedge pclk) disable iff (!presetn)
        !pulse_seen && !clear |=> $stable(count))
        else $error("count moved with no pulse and no clear");
endmodule : pulse_channel

// >>> pulse_counter_compare.sv
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ns
// How it works
// - two independent channels, numbered 0 and 1
// - each count is 32 bits, word readable
// - counts reliably up to 2 MHz pulses
// - counting in hardware, no software needed
// - channel 0 enable silences pwm 0-2
// - channel 0 counts only after explicit enable
// - channel 1 always counts, needs no setup
// - clear command zeroes that channel's count
// - reading a count does not disturb it
// - targets are 16 bits ch0, 8 bits ch1
// - on match drive port to programmed level
// - match fires when count exceeds target
module pulse_counter_compare
    import pulse_counter_pkg::*;
#(
    parameter logic [NUM_PORTS-1:0] INPUT_ONLY_MASK = 8'h00
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic [NUM_CHANNELS-1:0]   fast_pulse_counter,
    input  wire logic [NUM_PWM_SHARED-1:0] pwm_in,
    output logic [NUM_PWM_SHARED-1:0]      pwm_out,
    output logic [NUM_PORTS-1:0]           match_port_out,
    output logic [NUM_PORTS-1:0]           match_port_oe,
    output logic                           irq
);
    logic [COUNT_WIDTH-1:0]   count     [NUM_CHANNELS];
    logic [COUNT_WIDTH-1:0]   target_ext[NUM_CHANNELS];
    match_cfg_t               cfg_reg   [NUM_CHANNELS];
    logic [NUM_CHANNELS-1:0]  seen;
    logic [NUM_CHANNELS-1:0]  wrap;
    logic [NUM_CHANNELS-1:0]  chan_en;
    logic [NUM_CHANNELS-1:0]  clear_cmd;
    logic [NUM_CHANNELS-1:0]  hit;
    logic [NUM_CHANNELS-1:0]  rearm;
    logic [NUM_CHANNELS-1:0]  fired_reg;
    logic [NUM_CHANNELS-1:0]  fired_next;
    logic                     counter_zero_enable;
    logic [TARGET0_WIDTH-1:0] target0_reg;
    logic [TARGET1_WIDTH-1:0] target1_reg;
    logic [STATUS_WIDTH-1:0]  status_reg;
    logic [STATUS_WIDTH-1:0]  status_next;
    logic [STATUS_WIDTH-1:0]  mask_reg;
    logic [STATUS_WIDTH-1:0]  events;
    logic [NUM_PORTS-1:0]     port_lvl_reg;
    logic [NUM_PORTS-1:0]     port_oe_reg;
    logic [NUM_PWM_SHARED-1:0] pwm_reg;
    logic [31:0]              prdata_reg;
    logic                     irq_reg;
    logic                     setup;
    logic                     wr_en;
    logic                     mapped;
    logic [31:0]              rd_word;

    // apb decode; zero wait states, data captured in setup phase
    // capturing in setup keeps prdata a flop; the word is one cycle old at access
    assign setup   = psel & ~penable;
    assign wr_en   = psel & penable & pwrite;
    assign mapped  = (paddr == CTRL_OFS)       || (paddr == CLEAR_OFS)      ||
                     (paddr == COUNTER_ZERO_ENABLE_OFS)     || (paddr == COUNT1_OFS)     ||
                     (paddr == TARGET0_OFS)    || (paddr == TARGET1_OFS)    ||
                     (paddr == MATCH_CFG0_OFS) || (paddr == MATCH_CFG1_OFS) ||
                     (paddr == STATUS_OFS)     || (paddr == MASK_OFS)       ||
                     (paddr == PORTS_OFS);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = prdata_reg;
    assign irq     = irq_reg;

    // channel 0 needs its enable; channel 1 free-runs from reset
    assign chan_en = {1'b1, counter_zero_enable};
    assign clear_cmd = (wr_en && paddr == CLEAR_OFS) ?
                       pwdata[NUM_CHANNELS-1:0] : '0;

    // both channels are the same module; only enable, clear and pin differ
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
            pulse_channel #(.WIDTH(COUNT_WIDTH)) u_chan (
                .pclk       (pclk),
                .presetn    (presetn),
                .pulse_pin  (fast_pulse_counter[ch]),
                .enable     (chan_en[ch]),
                .clear      (clear_cmd[ch]),
                .count      (count[ch]),
                .pulse_seen (seen[ch]),
                .wrap       (wrap[ch])
            );
            // match once the count has moved past the target
            assign hit[ch] = cfg_reg[ch].arm & chan_en[ch] & ~fired_reg[ch] &
                             (count[ch] > target_ext[ch]);
        end
    endgenerate

    // targets are held narrow, so wider software values are cut
    // zero-extending them lets both channels share one compare expression
    assign target_ext[0] = {{(COUNT_WIDTH-TARGET0_WIDTH){1'b0}}, target0_reg};
    assign target_ext[1] = {{(COUNT_WIDTH-TARGET1_WIDTH){1'b0}}, target1_reg};

    // any write to a channel's target or setup arms it afresh
    assign rearm[0] = wr_en & (paddr == TARGET0_OFS || paddr == MATCH_CFG0_OFS);
    assign rearm[1] = wr_en & (paddr == TARGET1_OFS || paddr == MATCH_CFG1_OFS);
    // fired_reg stops a standing match from redriving the port each cycle
    assign fired_next = (fired_reg | hit) & ~rearm;

    // status: hardware set beats a write-one clear in the same cycle
    // wrap bits sit above the match bits, one per channel
    assign events      = {wrap, hit};
    assign status_next = (wr_en && paddr == STATUS_OFS) ?
                         ((status_reg & ~pwdata[STATUS_WIDTH-1:0]) | events) :
                         (status_reg | events);

    // read mux; counts are sampled, never altered, by a read
    assign rd_word =
        (paddr == CTRL_OFS)       ? {31'h0000_0000, counter_zero_enable} :
        (paddr == COUNTER_ZERO_ENABLE_OFS)     ? count[0] :
        (paddr == COUNT1_OFS)     ? count[1] :
        (paddr == TARGET0_OFS)    ? target_ext[0] :
        (paddr == TARGET1_OFS)    ? target_ext[1] :
        (paddr == MATCH_CFG0_OFS) ? {25'h000_0000, cfg_reg[0].port, 2'h0,
                                     cfg_reg[0].level, cfg_reg[0].arm} :
        (paddr == MATCH_CFG1_OFS) ? {25'h000_0000, cfg_reg[1].port, 2'h0,
                                     cfg_reg[1].level, cfg_reg[1].arm} :
        (paddr == STATUS_OFS)     ? {28'h000_0000, status_reg} :
        (paddr == MASK_OFS)       ? {28'h000_0000, mask_reg} :
        (paddr == PORTS_OFS)      ? {16'h0000, port_oe_reg, port_lvl_reg} :
                                    ZERO_WORD;

    // software-written configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_zero_enable <= 1'b0;
            target0_reg         <= '0;
            target1_reg         <= '0;
            cfg_reg[0]          <= MATCH_CFG_RESET;
            cfg_reg[1]          <= MATCH_CFG_RESET;
            mask_reg            <= '0;
        end else if (wr_en) begin
            // read-only and unmapped offsets fall to the default and change nothing
            case (paddr)
                CTRL_OFS:       counter_zero_enable <= pwdata[CTRL_ZERO_EN_BIT];
                TARGET0_OFS:    target0_reg <= pwdata[TARGET0_WIDTH-1:0];
                TARGET1_OFS:    target1_reg <= pwdata[TARGET1_WIDTH-1:0];
                MATCH_CFG0_OFS: cfg_reg[0] <= '{port:  pwdata[CFG_PORT_LSB +: PORT_SEL_WIDTH],
                                                level: pwdata[CFG_LEVEL_BIT],
                                                arm:   pwdata[CFG_ARM_BIT]};
                MATCH_CFG1_OFS: cfg_reg[1] <= '{port:  pwdata[CFG_PORT_LSB +: PORT_SEL_WIDTH],
                                                level: pwdata[CFG_LEVEL_BIT],
                                                arm:   pwdata[CFG_ARM_BIT]};
                MASK_OFS:       mask_reg <= pwdata[STATUS_WIDTH-1:0];
                default:        mask_reg <= mask_reg;
            endcase
        end
    end

    // status, interrupt, read data and shared pwm gating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= '0;
            fired_reg  <= '0;
            irq_reg    <= 1'b0;
            prdata_reg <= ZERO_WORD;
            pwm_reg    <= '0;
        end else begin
            status_reg <= status_next;
            fired_reg  <= fired_next;
            irq_reg    <= |(status_next & mask_reg);
            prdata_reg <= (setup && !pwrite) ? rd_word : prdata_reg;
            pwm_reg    <= counter_zero_enable ? '0 : pwm_in;
        end
    end
    // gating is registered, so pwm stops one cycle after the enable write
    assign pwm_out = pwm_reg;

    // compare drives its chosen port; channel 1 wins a same-cycle clash.
    // input-only ports are never enabled, a guard against a bad setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_lvl_reg <= '0;
            port_oe_reg  <= '0;
        end else begin
            // a later channel in the loop overrides an earlier one on a shared port
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                if (hit[i]) begin
                    port_lvl_reg[cfg_reg[i].port] <= cfg_reg[i].level;
                    port_oe_reg[cfg_reg[i].port]  <=
                        ~INPUT_ONLY_MASK[cfg_reg[i].port];
                end
            end
        end
    end
    assign match_port_out = port_lvl_reg;
    assign match_port_oe  = port_oe_reg;

    // per-rule checks on the counting, compare, pwm gating, interrupt and bus error paths
    chk_pwm_gated: assert property (@(posedge pclk) disable iff (!presetn)
        counter_zero_enable ##1 counter_zero_enable |-> pwm_out == '0)
        else $error("shared pwm active while channel 0 counts");
    chk_zero_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !counter_zero_enable && !clear_cmd[0] |=> $stable(count[0]))
        else $error("channel 0 counted while disabled");
    chk_chan1_free: assert property (@(posedge pclk) disable iff (!presetn)
        seen[1] && !clear_cmd[1] |=> count[1] != $past(count[1]))
        else $error("channel 1 ignored a pulse");
    chk_clear_zero: assert property (@(posedge pclk) disable iff (!presetn)
        clear_cmd[0] |=> count[0] == '0)
        else $error("clear did not zero channel 0");
    chk_match_level: assert property (@(posedge pclk) disable iff (!presetn)
        hit[1] |=> match_port_out[$past(cfg_reg[1].port)] == $past(cfg_reg[1].level))
        else $error("port not driven to programmed level");
    chk_match_moment: assert property (@(posedge pclk) disable iff (!presetn)
        hit[0] |-> count[0] > target_ext[0] && count[0] != '0)
        else $error("match fired at or below target");
    chk_target_width: assert property (@(posedge pclk) disable iff (!presetn)
        target_ext[1] <= 32'h0000_00ff && target_ext[0] <= 32'h0000_ffff)
        else $error("target wider than allowed");
    chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        (|(status_reg & mask_reg)) |-> irq || $past(!(|(status_reg & mask_reg))))
        else $error("interrupt low with unmasked status set");
    chk_apb_error: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && mapped |-> !pslverr)
        else $error("error on a mapped address");

    // bus side: refused writes land nowhere, read data stands until the next read
    chk_refused_write: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pwrite && !mapped |=>
            $stable(mask_reg) && $stable(counter_zero_enable) && $stable(target0_reg))
        else $error("write to an unmapped address took effect");
    chk_read_capture: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && paddr == COUNT1_OFS |=> prdata == $past(count[1]))
        else $error("read did not return the channel count");
    chk_prdata_holds: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved with no read");
    chk_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == CTRL_OFS |=> counter_zero_enable == $past(pwdata[CTRL_ZERO_EN_BIT]))
        else $error("channel 0 enable not taken from the write");
    chk_target_load: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == TARGET1_OFS |=> target1_reg == $past(pwdata[TARGET1_WIDTH-1:0]))
        else $error("channel 1 target not loaded");
    chk_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == MASK_OFS |=> mask_reg == $past(pwdata[STATUS_WIDTH-1:0]))
        else $error("mask not loaded");

    // status and interrupt: a new event always survives a same-cycle clear
    chk_status_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (|events) |=> (status_reg & $past(events)) == $past(events))
        else $error("status event lost");
    chk_status_w1c: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == STATUS_OFS && !(|events) |=>
            (status_reg & $past(pwdata[STATUS_WIDTH-1:0])) == '0)
        else $error("status bit survived a write-one clear");
    chk_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
        !(|mask_reg) ##1 !(|mask_reg) |-> !irq)
        else $error("interrupt raised with every source masked");

    // compare unit: one firing per arming, port held between firings
    chk_fire_once0: assert property (@(posedge pclk) disable iff (!presetn)
        hit[0] && !rearm[0] |=> !hit[0])
        else $error("channel 0 match fired twice");
    chk_fire_once1: assert property (@(posedge pclk) disable iff (!presetn)
        hit[1] && !rearm[1] |=> !hit[1])
        else $error("channel 1 match fired twice");
    chk_match_level0: assert property (@(posedge pclk) disable iff (!presetn)
        hit[0] && !hit[1] |=>
            match_port_out[$past(cfg_reg[0].port)] == $past(cfg_reg[0].level))
        else $error("channel 0 port not driven to programmed level");
    chk_ports_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(|hit) |=> $stable(match_port_out) && $stable(match_port_oe))
        else $error("match port changed with no match");
    chk_port_enable: assert property (@(posedge pclk) disable iff (!presetn)
        hit[1] |=> match_port_oe[$past(cfg_reg[1].port)] !=
            INPUT_ONLY_MASK[$past(cfg_reg[1].port)])
        else $error("port enable does not follow the input-only guard");

    // shared pwm passes through while channel 0 is off; channel 1 clears too
    chk_pwm_pass: assert property (@(posedge pclk) disable iff (!presetn)
        !counter_zero_enable |=> pwm_out == $past(pwm_in))
        else $error("pwm blocked while channel 0 is off");
    chk_clear_one: assert property (@(posedge pclk) disable iff (!presetn)
        clear_cmd[1] |=> count[1] == '0)
        else $error("clear did not zero channel 1");

    // main scenarios: each match, a wrap, the interrupt and a status clear
    cov_match0: cover property (@(posedge pclk) disable iff (!presetn) hit[0]);
    cov_match1: cover property (@(posedge pclk) disable iff (!presetn) hit[1]);
    cov_wrap:   cover property (@(posedge pclk) disable iff (!presetn) |wrap);
    cov_irq:    cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    cov_w1c:    cover property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == STATUS_OFS && (|status_reg));
endmodule : pulse_counter_compare

// >>> pulse_counter_pkg.sv
package pulse_counter_pkg;

    // channel geometry
    localparam int unsigned NUM_CHANNELS   = 2;
    localparam int unsigned COUNT_WIDTH    = 32;
    localparam int unsigned TARGET0_WIDTH  = 16;
    localparam int unsigned TARGET1_WIDTH  = 8;
    localparam int unsigned NUM_PORTS      = 8;
    localparam int unsigned PORT_SEL_WIDTH = 3;
    localparam int unsigned NUM_PWM_SHARED = 3;

    // input pulse timing: fastest source is 2 MHz on a 100 MHz pclk
    localparam int unsigned CLK_PERIOD_NS       = 10;
    localparam int unsigned MIN_PULSE_PERIOD_NS = 500;
    localparam int unsigned MIN_PULSE_CYCLES    = MIN_PULSE_PERIOD_NS / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS       = 8'h00;
    localparam logic [7:0] CLEAR_OFS      = 8'h04;
    localparam logic [7:0] COUNTER_ZERO_ENABLE_OFS     = 8'h08;
    localparam logic [7:0] COUNT1_OFS     = 8'h0c;
    localparam logic [7:0] TARGET0_OFS    = 8'h10;
    localparam logic [7:0] TARGET1_OFS    = 8'h14;
    localparam logic [7:0] MATCH_CFG0_OFS = 8'h18;
    localparam logic [7:0] MATCH_CFG1_OFS = 8'h1c;
    localparam logic [7:0] STATUS_OFS     = 8'h20;
    localparam logic [7:0] MASK_OFS       = 8'h24;
    localparam logic [7:0] PORTS_OFS      = 8'h28;

    // field positions
    localparam int unsigned CTRL_ZERO_EN_BIT = 0;
    localparam int unsigned CFG_ARM_BIT      = 0;
    localparam int unsigned CFG_LEVEL_BIT    = 1;
    localparam int unsigned CFG_PORT_LSB     = 4;
    localparam int unsigned ST_MATCH_LSB     = 0;
    localparam int unsigned ST_WRAP_LSB      = 2;
    localparam int unsigned STATUS_WIDTH     = 4;

    // reset values
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // compare setup of one channel
    typedef struct packed {
        logic [PORT_SEL_WIDTH-1:0] port;
        logic                      level;
        logic                      arm;
    } match_cfg_t;

    localparam match_cfg_t MATCH_CFG_RESET = '0;

endpackage : pulse_counter_pkg

// >>> pulse_source.sv
`timescale 1ns/1ns
// far-side pulse source that drives the two counter pins
module pulse_source (
    input  wire logic       pclk,
    output logic      [1:0] pins
);
    // the pins are only ever driven from here, never by the block
    initial pins = 2'b00;

    // one pulse train; each phase is held half_cyc edges, and 25 is the 2 mhz limit
    // the pin is always driven, so it never floats between trains
    task automatic send(input int ch, input int n, input int half_cyc);
        for (int i = 0; i < n; i++) begin
            repeat (half_cyc) @(posedge pclk);
            pins[ch] <= 1'b1;
            repeat (half_cyc) @(posedge pclk);
            pins[ch] <= 1'b0;
        end
        // synchroniser plus edge detect need a few edges before the count moves
        repeat (8) @(posedge pclk);
    endtask : send
endmodule : pulse_source

// >>> sync_two_stage.sv
`timescale 1ns/1ns
// two-flop synchroniser for one asynchronous level
module sync_two_stage (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_reg;

    // only the second flop reads the first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : sync_two_stage

// >>> test_pulse_counter_compare.sv
`timescale 1ns/1ns
// wrap of a full 32-bit count is not reached here: four billion pulses will not fit a run
module test_pulse_counter_compare;
    import pulse_counter_pkg::*;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  pins;
    logic [2:0]  pwm_in;
    logic [2:0]  pwm_out;
    logic [7:0]  mport;
    logic [7:0]  moe;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    logic [31:0] lfsr_state;
    int          miscompares;
    int          cmp_count;
    int          acc;
    int          n;
    int          t;
    int          p;

    pulse_counter_compare i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fast_pulse_counter(pins), .pwm_in(pwm_in), .pwm_out(pwm_out),
        .match_port_out(mport), .match_port_oe(moe), .irq(irq)
    );

    pulse_source i_src (.pclk(pclk), .pins(pins));

    always #5 pclk = ~pclk;

    // repeatable random source
    function automatic int rnd(input int k);
        lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
        return int'(lfsr_state[15:0]) % k;
    endfunction : rnd

    // expected target readback: channel 0 keeps 16 bits, channel 1 keeps 8
    function automatic logic [31:0] exp_target(input int ch, input logic [31:0] v);
        return (ch == 0) ? {16'h0000, v[15:0]} : {24'h000000, v[7:0]};
    endfunction : exp_target

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // settle past the edge so registered outputs are read after they land
    task automatic settle(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask : settle

    // one apb transfer; request held until pready is seen high at a rising edge
    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int w;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        w = 0;
        do begin
            @(posedge pclk);
            w++;
        end while (pready !== 1'b1 && w < 20);
        if (pready !== 1'b1) begin
            miscompares++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    initial begin
        #900000;
        miscompares++;
        final_report();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pwm_in = 3'h0;
        lfsr_state = 32'h59e65b1f;
        miscompares = 0;
        cmp_count = 0;
        acc = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // reset values of every readable register, then an unmapped word
        for (int a = 0; a <= 'h28; a += 4) begin
            if (a != 4) begin
                apb_xfer(1'b0, a[7:0], 32'h0);
                check(rd, ZERO_WORD);
            end
        end
        apb_xfer(1'b0, 8'h2c, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, ZERO_WORD);
        apb_xfer(1'b1, COUNT1_OFS, 32'h1234_5678);
        apb_xfer(1'b0, COUNT1_OFS, 32'h0);
        check(rd, ZERO_WORD);
        // channel 1 counts with no setup, and reads leave the count alone
        for (int it = 0; it < 3; it++) begin
            n = 1 + rnd(7);
            i_src.send(1, n, 25 + rnd(8));
            acc += n;
            apb_xfer(1'b0, COUNT1_OFS, 32'h0);
            check(rd, acc);
            apb_xfer(1'b0, COUNT1_OFS, 32'h0);
            check(rd, acc);
        end
        // channel 0 stays still until enabled, and pwm passes while it is off
        i_src.send(0, 3, 25);
        apb_xfer(1'b0, COUNTER_ZERO_ENABLE_OFS, 32'h0);
        check(rd, ZERO_WORD);
        @(posedge pclk);
        pwm_in <= 3'(rnd(8)) | 3'h1;
        settle(3);
        check({29'h0, pwm_out}, {29'h0, pwm_in});
        apb_xfer(1'b1, CTRL_OFS, 32'h1); // enable before any compare on channel 0
        settle(3);
        check({29'h0, pwm_out}, 32'h0);
        n = 1 + rnd(5);
        i_src.send(0, n, 25);
        apb_xfer(1'b0, COUNTER_ZERO_ENABLE_OFS, 32'h0);
        check(rd, n);
        apb_xfer(1'b0, COUNT1_OFS, 32'h0);
        check(rd, acc);
        // clear hits only the addressed channel
        apb_xfer(1'b1, CLEAR_OFS, 32'h1);
        apb_xfer(1'b0, COUNTER_ZERO_ENABLE_OFS, 32'h0);
        check(rd, ZERO_WORD);
        apb_xfer(1'b0, COUNT1_OFS, 32'h0);
        check(rd, acc);
        // target width limits
        for (int ch = 0; ch < 2; ch++) begin
            apb_xfer(1'b1, ch ? TARGET1_OFS : TARGET0_OFS, 32'hffff_ffff);
            apb_xfer(1'b0, ch ? TARGET1_OFS : TARGET0_OFS, 32'h0);
            check(rd, exp_target(ch, 32'hffff_ffff));
        end
        // compare per channel: level 1 on channel 0, level 0 on channel 1
        p = rnd(8);
        for (int ch = 0; ch < 2; ch++) begin
            t = 2 + rnd(4);
            // one port for both channels, so each level flips what the last one left
            apb_xfer(1'b1, CLEAR_OFS, 32'h3);
            apb_xfer(1'b1, ch ? TARGET1_OFS : TARGET0_OFS, t);
            apb_xfer(1'b1, ch ? MATCH_CFG1_OFS : MATCH_CFG0_OFS,
                     {25'h0, 3'(p), 2'b00, 1'(ch == 0), 1'b1}); // no input-only port
            i_src.send(ch, t, 25);
            settle(1);
            check({31'h0, moe[p]}, {31'h0, 1'(ch == 1)});
            check({31'h0, mport[p]}, {31'h0, 1'(ch == 1)});
            i_src.send(ch, 1, 25);
            settle(1);
            check({31'h0, moe[p]}, 32'h1);
            check({31'h0, mport[p]}, {31'h0, 1'(ch == 0)});
            apb_xfer(1'b0, STATUS_OFS, 32'h0);
            check({31'h0, rd[ch]}, 32'h1);
            check({31'h0, irq}, 32'h0);
            apb_xfer(1'b1, MASK_OFS, 32'h1 << ch);
            settle(3);
            check({31'h0, irq}, 32'h1);
            apb_xfer(1'b1, STATUS_OFS, 32'h1 << ch);
            settle(3);
            check({31'h0, irq}, 32'h0);
            apb_xfer(1'b1, MASK_OFS, 32'h0);
        end
        final_report();
    end
endmodule : test_pulse_counter_compare
